// ### design/usb_status_pkg.sv
// What this block does
// - endpoint 0 receive sets bit 10; 9 reserved
// - setup token on endpoint 0 sets bit 8
// - bus supply rising edge sets bit 7
// - dma reason change sets bit 6
// - full to high speed sets bit 5
// - leaving suspend sets bit 4
// - entering suspend sets bit 3
// - free running frame tick sets bit 2
// - received frame marker sets bit 1
// - bus reset sets bit 0 outside otg
// - otg mode: 2 ms se0 sets bit 0
// - read-only 24-bit identity register layout
// - frame and microframe numbers, read-only
// - byte reads return low byte first
// - 16-bit scratch register, no side effects
// - scratch bytes cleared by both resets
// - status zero at reset, bus reset bit0 outside otg, zero in otg
package usb_status_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
    localparam logic [7:0] CONTROL_OFS    = 8'h1c;
    localparam logic [7:0] IDENTITY_OFS   = 8'h70;
    localparam logic [7:0] FRAME_OFS      = 8'h74;
    localparam logic [7:0] SCRATCH_OFS    = 8'h78;

    // ----------------------------------------
    // interrupt status bit positions
    // ----------------------------------------
    localparam int IRQ_BITS          = 11;
    localparam int BUS_RESET_BIT     = 0;
    localparam int SOF_BIT           = 1;
    localparam int FRAME_TICK_BIT    = 2;
    localparam int SUSPEND_BIT       = 3;
    localparam int RESUME_BIT        = 4;
    localparam int HIGHSPEED_BIT     = 5;
    localparam int DMA_BIT           = 6;
    localparam int VBUS_BIT          = 7;
    localparam int SETUP_BIT         = 8;
    localparam int RESERVED_IRQ_BIT  = 9;
    localparam int CTRL_RX_BIT       = 10;
    localparam logic [IRQ_BITS-1:0] IRQ_CHIP_RESET = 11'h000;
    localparam logic [IRQ_BITS-1:0] IRQ_BUS_RESET  = 11'h001;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int OTG_ENABLE_BIT  = 0;
    localparam int BYTE_ACCESS_BIT = 1;
    localparam logic [1:0] CONTROL_RESET = 2'h0;

    // ----------------------------------------
    // identity and frame fields
    // ----------------------------------------
    localparam int PART_LOW_LSB  = 16;
    localparam int PART_HIGH_LSB = 8;
    localparam int REVISION_LSB  = 0;
    localparam int FRAME_W       = 11;
    localparam int MICRO_W       = 3;
    localparam int MICRO_LSB     = 11;
    localparam logic [13:0] FRAME_RESET   = 14'h0000;
    localparam logic [15:0] SCRATCH_RESET = 16'h0000;

    // ----------------------------------------
    // times and derived cycle counts
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int FS_FRAME_MS     = 1;
    localparam int HS_FRAME_US     = 125;
    localparam int SE0_HOLD_MS     = 2;
    localparam int FS_FRAME_CYCLES = FS_FRAME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int HS_FRAME_CYCLES = HS_FRAME_US * 1000 / CLK_PERIOD_NS;
    localparam int SE0_HOLD_CYCLES = SE0_HOLD_MS * 1000000 / CLK_PERIOD_NS;

endpackage

// ### design/frame_tick_gen.sv
`timescale 1ns/1ns
module frame_tick_gen #(
    parameter int FS_CYCLES = usb_status_pkg::FS_FRAME_CYCLES,
    parameter int HS_CYCLES = usb_status_pkg::HS_FRAME_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic high_speed,
    output logic      tick
);

    localparam int CNT_W = $clog2(FS_CYCLES + 1);

    generate
        if (FS_CYCLES < 2 || HS_CYCLES < 2 ||
            HS_CYCLES > FS_CYCLES) begin : g_chk
            $error("frame_tick_gen: bad period");
        end
    endgenerate

    logic [CNT_W-1:0] count_q;
    logic             speed_q;
    logic             tick_q;

    // ----------------------------------------
    // free running period counter
    // ----------------------------------------
    // not aligned to bus markers on purpose: keeps ticking when none arrive
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            speed_q <= 1'b0;
        end else begin
            speed_q <= high_speed;
            if (speed_q != high_speed) begin
                count_q <= '0;
            end else if (high_speed && count_q >= CNT_W'(HS_CYCLES - 1)) begin
                count_q <= '0;
            end else if (count_q >= CNT_W'(FS_CYCLES - 1)) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (speed_q == high_speed) &&
                      (high_speed ? count_q == CNT_W'(HS_CYCLES - 1)
                                  : count_q == CNT_W'(FS_CYCLES - 1));
        end
    end

    assign tick = tick_q;

endmodule

// ### design/usb_device_status_regs.sv
`timescale 1ns/1ns
module usb_device_status_regs #(
    parameter int             FS_CYCLES    = usb_status_pkg::FS_FRAME_CYCLES,
    parameter int             HS_CYCLES    = usb_status_pkg::HS_FRAME_CYCLES,
    parameter int             SE0_CYCLES   = usb_status_pkg::SE0_HOLD_CYCLES,
    parameter int             DMA_REASON_W = 16,
    // arbitrary identity values, not those of any part
    parameter logic [15:0]    PART_CODE    = 16'h5aa5,
    parameter logic [7:0]     HW_REVISION  = 8'h01
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [31:0]             rdata,
    input  wire logic                    ctrl_ep_rx_event,
    input  wire logic                    ctrl_ep_setup_event,
    input  wire logic                    vbus_sense,
    input  wire logic [DMA_REASON_W-1:0] dma_reason,
    input  wire logic                    high_speed,
    input  wire logic                    bus_suspended,
    input  wire logic                    sof_valid,
    input  wire logic [10:0]             sof_frame,
    input  wire logic [2:0]              sof_micro,
    input  wire logic                    bus_reset_event,
    input  wire logic                    se0_seen,
    output logic                         frame_tick,
    output logic                         otg_mode
);

    localparam int SE0_W = $clog2(SE0_CYCLES + 1);
    localparam int NIRQ  = usb_status_pkg::IRQ_BITS;

    generate
        if (SE0_CYCLES < 2 || DMA_REASON_W < 1) begin : g_chk
            $error("usb_device_status_regs: bad parameter");
        end
    endgenerate

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic sel_irq;
    logic sel_ctrl;
    logic sel_id;
    logic sel_frame;
    logic sel_scratch;

    assign sel_irq     = addr == usb_status_pkg::IRQ_STATUS_OFS;
    assign sel_ctrl    = addr == usb_status_pkg::CONTROL_OFS;
    assign sel_id      = addr == usb_status_pkg::IDENTITY_OFS;
    assign sel_frame   = addr == usb_status_pkg::FRAME_OFS;
    assign sel_scratch = addr == usb_status_pkg::SCRATCH_OFS;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic [1:0] control_q;
    logic       byte_access;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= usb_status_pkg::CONTROL_RESET;
        end else if (wr_en && sel_ctrl) begin
            control_q <= wdata[1:0];
        end
    end

    assign otg_mode    = control_q[usb_status_pkg::OTG_ENABLE_BIT];
    assign byte_access = control_q[usb_status_pkg::BYTE_ACCESS_BIT];

    // ----------------------------------------
    // input edge detection
    // ----------------------------------------
    logic                    vbus_q;
    logic                    hs_q;
    logic                    suspend_irq_q;
    logic [DMA_REASON_W-1:0] dma_prev_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vbus_q     <= 1'b0;
            hs_q       <= 1'b0;
            suspend_irq_q     <= 1'b0;
            dma_prev_q <= '0;
        end else begin
            vbus_q     <= vbus_sense;
            hs_q       <= high_speed;
            suspend_irq_q     <= bus_suspended;
            dma_prev_q <= dma_reason;
        end
    end

    // ----------------------------------------
    // se0 hold timer for otg mode
    // ----------------------------------------
    logic [SE0_W-1:0] se0_count_q;
    logic             se0_hit;

    // saturates so one long se0 raises the flag only once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            se0_count_q <= '0;
        end else if (!se0_seen || !otg_mode) begin
            se0_count_q <= '0;
        end else if (se0_count_q != SE0_W'(SE0_CYCLES)) begin
            se0_count_q <= se0_count_q + 1'b1;
        end
    end

    assign se0_hit = se0_seen && otg_mode &&
                     se0_count_q == SE0_W'(SE0_CYCLES - 1);

    // ----------------------------------------
    // internal frame tick
    // ----------------------------------------
    logic tick;

    frame_tick_gen #(
        .FS_CYCLES (FS_CYCLES),
        .HS_CYCLES (HS_CYCLES)
    ) u_tick (
        .clk        (clk),
        .reset_n    (reset_n),
        .high_speed (high_speed),
        .tick       (tick)
    );

    assign frame_tick = tick;

    // ----------------------------------------
    // interrupt events
    // ----------------------------------------
    logic [NIRQ-1:0] irq_event;

    always_comb begin
        irq_event = '0;
        irq_event[usb_status_pkg::CTRL_RX_BIT] = ctrl_ep_rx_event;
        irq_event[usb_status_pkg::SETUP_BIT] = ctrl_ep_setup_event;
        irq_event[usb_status_pkg::VBUS_BIT] = vbus_sense && !vbus_q;
        irq_event[usb_status_pkg::DMA_BIT] =
            dma_reason != dma_prev_q;
        // a drop to full speed or a suspend never raises it
        irq_event[usb_status_pkg::HIGHSPEED_BIT] =
            high_speed && !hs_q;
        irq_event[usb_status_pkg::RESUME_BIT] =
            !bus_suspended && suspend_irq_q;
        irq_event[usb_status_pkg::SUSPEND_BIT] =
            bus_suspended && !suspend_irq_q;
        irq_event[usb_status_pkg::FRAME_TICK_BIT] = tick;
        irq_event[usb_status_pkg::SOF_BIT] = sof_valid;
        irq_event[usb_status_pkg::BUS_RESET_BIT] = se0_hit;
    end

    // ----------------------------------------
    // sticky interrupt status
    // ----------------------------------------
    logic [NIRQ-1:0] irq_q;
    logic [NIRQ-1:0] irq_bus_reset_val;

    always_comb begin
        irq_bus_reset_val = usb_status_pkg::IRQ_CHIP_RESET;
        if (!otg_mode) begin
            irq_bus_reset_val = usb_status_pkg::IRQ_BUS_RESET;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NIRQ; gi++) begin : g_irq
            if (gi == usb_status_pkg::RESERVED_IRQ_BIT) begin : g_rsv
                assign irq_q[gi] = 1'b0;
            end else begin : g_bit
                always_ff @(posedge clk or negedge reset_n) begin
                    if (!reset_n) begin
                        irq_q[gi] <=
                            usb_status_pkg::IRQ_CHIP_RESET[gi];
                    end else if (bus_reset_event) begin
                        irq_q[gi] <= irq_bus_reset_val[gi];
                    end else if (irq_event[gi]) begin
                        // set beats a clear in the same cycle
                        irq_q[gi] <= 1'b1;
                    end else if (wr_en && sel_irq && wdata[gi]) begin
                        irq_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // frame number register
    // ----------------------------------------
    logic [13:0] frame_q;

    // one wide register, so both fields always move together
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_q <= usb_status_pkg::FRAME_RESET;
        end else if (bus_reset_event) begin
            frame_q <= usb_status_pkg::FRAME_RESET;
        end else if (sof_valid) begin
            frame_q <= {sof_micro, sof_frame};
        end
    end

    // ----------------------------------------
    // byte-wide frame read sequencing
    // ----------------------------------------
    logic       high_next_q;
    logic [7:0] high_hold_q;

    // high byte is frozen at the low-byte read, so a marker
    // landing between the two reads cannot tear the value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            high_next_q <= 1'b0;
            high_hold_q <= 8'h00;
        end else if (!byte_access) begin
            high_next_q <= 1'b0;
        end else if (rd_en && sel_frame) begin
            high_next_q <= !high_next_q;
            if (!high_next_q) begin
                high_hold_q <= {2'b00, frame_q[13:8]};
            end
        end
    end

    // ----------------------------------------
    // scratch register
    // ----------------------------------------
    logic [7:0] scratch_high_byte_q;
    logic [7:0] scratch_low_byte_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scratch_high_byte_q <= usb_status_pkg::SCRATCH_RESET[15:8];
            scratch_low_byte_q  <= usb_status_pkg::SCRATCH_RESET[7:0];
        end else if (bus_reset_event) begin
            scratch_high_byte_q <=
                usb_status_pkg::SCRATCH_RESET[15:8];
            scratch_low_byte_q  <=
                usb_status_pkg::SCRATCH_RESET[7:0];
        end else if (wr_en && sel_scratch) begin
            scratch_high_byte_q <= wdata[15:8];
            scratch_low_byte_q  <= wdata[7:0];
        end
    end

    // ----------------------------------------
    // identity word
    // ----------------------------------------
    logic [23:0] part_identity;

    assign part_identity = {PART_CODE[7:0],
                            PART_CODE[15:8],
                            HW_REVISION};

    // ----------------------------------------
    // read mux and read data register
    // ----------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_en) begin
            if (sel_irq) begin
                rdata_d[NIRQ-1:0] = irq_q;
            end else if (sel_ctrl) begin
                rdata_d[1:0] = control_q;
            end else if (sel_id) begin
                rdata_d[23:0] = part_identity;
            end else if (sel_frame && byte_access) begin
                rdata_d[7:0] = high_next_q ? high_hold_q
                                           : frame_q[7:0];
            end else if (sel_frame) begin
                rdata_d[13:0] = frame_q;
            end else if (sel_scratch) begin
                rdata_d[15:0] = {scratch_high_byte_q,
                                 scratch_low_byte_q};
            end
        end
    end

    // unmapped and write-only accesses read as zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule

// ### sim/usb_status_assertions.sv
`timescale 1ns/1ns
// ------
// register, bus and tick checks
// ------
module usb_status_checker #(
    parameter int          FS_CYCLES   = 20,
    parameter int          HS_CYCLES   = 5,
    parameter logic [15:0] PART_CODE   = 16'h0000,
    parameter logic [7:0]  HW_REVISION = 8'h00
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        high_speed,
    input wire logic        bus_reset_event,
    input wire logic        frame_tick,
    input wire logic        otg_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] scr_q;
    logic [31:0] gap_q;
    logic        gap_ok_q;
    logic        hs_q;
    // scratch shadow; bus reset beats a write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scr_q <= 16'h0000;
        end else if (bus_reset_event) begin
            scr_q <= 16'h0000;
        end else if (wr_en && addr == 8'h78) begin
            scr_q <= wdata[15:0];
        end
    end
    // restart timing after a speed change is left open, so void the gap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q    <= 32'h0;
            gap_ok_q <= 1'b0;
            hs_q     <= 1'b0;
        end else begin
            hs_q  <= high_speed;
            gap_q <= (frame_tick || high_speed != hs_q) ? 32'h0
                                                        : gap_q + 32'h1;
            if (high_speed != hs_q) begin
                gap_ok_q <= 1'b0;
            end else if (frame_tick) begin
                gap_ok_q <= 1'b1;
            end
        end
    end
    a_id_word: assert property (
        $past(rd_en) && $past(addr) == 8'h70 |-> rdata == {8'h00,
        PART_CODE[7:0], PART_CODE[15:8], HW_REVISION})
        else $error("identity word wrong");
    a_irq_reserved: assert property (
        $past(rd_en) && $past(addr) == 8'h18 |-> rdata[31:11] == 21'h0
        && !rdata[9]) else $error("reserved status bits set");
    a_frame_upper: assert property (
        $past(rd_en) && $past(addr) == 8'h74 |-> rdata[31:14] == 18'h0)
        else $error("frame reserved bits set");
    a_scratch_value: assert property (
        $past(rd_en) && $past(addr) == 8'h78
        |-> rdata == {16'h0000, $past(scr_q)})
        else $error("scratch value wrong");
    a_otg_follow: assert property (
        $past(wr_en) && $past(addr) == 8'h1c |-> otg_mode == $past(wdata[0]))
        else $error("otg mode not taken");
    a_bus_reset_status: assert property (
        bus_reset_event ##[1:4] (rd_en && addr == 8'h18)
        |=> {rdata[10:3], rdata[1:0]} == {9'h000, !$past(otg_mode)})
        else $error("status after bus reset wrong");
    a_tick_pulse: assert property (
        frame_tick |=> !frame_tick) else $error("tick wider than one cycle");
    a_tick_period: assert property (
        frame_tick && gap_ok_q && high_speed == hs_q
        |-> gap_q == (high_speed ? HS_CYCLES - 1 : FS_CYCLES - 1))
        else $error("tick period wrong");
endmodule

// ### sim/host_fw_model.sv
`timescale 1ns/1ns
// ------
// firmware side of the register port
// ------
module host_fw_model (
    input  wire logic        clk,
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr_en,
    output logic             rd_en,
    input  wire logic [31:0] rdata
);
    initial begin
        addr  = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // identity is read here first, before features are used
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
// ------
// bench top
// ------
module tb;
    localparam logic [31:0] NO_TICK = 32'hffff_fffb;
    logic        clk, reset_n, wr_en, rd_en, rx_ev, setup_ev, vbus, hs;
    logic        suspend_irq, sof, brst, se0, frame_tick, otg_mode;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [15:0] dma;
    int          fails, compares, n;
    int          bits[8] = '{10, 8, 7, 6, 5, 3, 4, 1};
    host_fw_model host_fw_model_inst (.clk(clk), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
    usb_device_status_regs #(.FS_CYCLES(20), .HS_CYCLES(5), .SE0_CYCLES(10))
    usb_device_status_regs_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ctrl_ep_rx_event(rx_ev), .ctrl_ep_setup_event(setup_ev),
        .vbus_sense(vbus), .dma_reason(dma), .high_speed(hs),
        .bus_suspended(suspend_irq), .sof_valid(sof), .sof_frame(11'h5a3),
        .sof_micro(3'h6), .bus_reset_event(brst), .se0_seen(se0),
        .frame_tick(frame_tick), .otg_mode(otg_mode));
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_word(input string name, input logic [31:0] exp,
                              input logic [31:0] got, input logic [31:0] m);
        compares++;
        if ((got & m) !== (exp & m)) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp & m,
                     got & m);
        end
    endtask
    task automatic rd_check(input string name, input logic [7:0] a,
                            input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        host_fw_model_inst.rd(a, d);
        check_word(name, exp, d, m);
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        case (b)
            10: rx_ev <= 1'b1;
            8: setup_ev <= 1'b1;
            7: vbus <= 1'b1;
            6: dma <= dma + 16'h0001;
            5: hs <= 1'b1;
            3: suspend_irq <= 1'b1;
            4: suspend_irq <= 1'b0;
            1: sof <= 1'b1;
            default: brst <= 1'b1;
        endcase
        @(posedge clk);
        rx_ev    <= 1'b0;
        setup_ev <= 1'b0;
        sof      <= 1'b0;
        brst     <= 1'b0;
    endtask
    // bounded wait, then cycles to the next tick
    task automatic tick_gap();
        #1;
        n = 0;
        while (!frame_tick && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n < 100) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (!frame_tick && n < 100);
        end
        if (n >= 100) begin
            fails++;
            finish_test();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reset_n, rx_ev, setup_ev, vbus, hs, suspend_irq, sof, brst, se0} = '0;
        dma = 16'h0000;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd_check("identity", 8'h70, 32'h00a55a01, '1);
        rd_check("status", 8'h18, 32'h0, NO_TICK);
        rd_check("frame", 8'h74, 32'h0, '1);
        rd_check("scratch", 8'h78, 32'h0, '1);
        rd_check("unmapped", 8'h40, 32'h0, '1);
        host_fw_model_inst.wr(8'h70, 32'hffffffff);
        host_fw_model_inst.wr(8'h74, 32'hffffffff);
        rd_check("identity ro", 8'h70, 32'h00a55a01, '1);
        rd_check("frame ro", 8'h74, 32'h0, '1);
        foreach (bits[i]) begin
            pulse(bits[i]);
            rd_check("irq set", 8'h18, 32'h1 << bits[i],
                     NO_TICK);
            rd_check("irq held", 8'h18, 32'h1 << bits[i], NO_TICK);
            host_fw_model_inst.wr(8'h18, 32'h1 << bits[i]);
            rd_check("irq clear", 8'h18, 32'h0, NO_TICK);
        end
        @(posedge clk);
        hs <= 1'b0;
        rd_check("hs fall", 8'h18, 32'h0, NO_TICK);
        rd_check("frame word", 8'h74, 32'h000035a3, '1);
        host_fw_model_inst.wr(8'h1c, 32'h2);
        rd_check("frame low", 8'h74, 32'h000000a3, '1);
        rd_check("frame high", 8'h74, 32'h00000035, '1);
        host_fw_model_inst.wr(8'h1c, 32'h0);
        host_fw_model_inst.wr(8'h78, 32'h1234abcd);
        rd_check("scratch rw", 8'h78, 32'h0000abcd, '1);
        pulse(8);
        pulse(0);
        rd_check("bus reset", 8'h18, 32'h1, NO_TICK);
        rd_check("scratch clr", 8'h78, 32'h0, '1);
        rd_check("frame clr", 8'h74, 32'h0, '1);
        host_fw_model_inst.wr(8'h18, 32'h1);
        host_fw_model_inst.wr(8'h1c, 32'h1);
        @(negedge clk);
        check_word("otg_mode", 32'h1, {31'h0, otg_mode}, '1);
        pulse(0);
        rd_check("otg bus reset", 8'h18, 32'h0, NO_TICK);
        @(posedge clk);
        se0 <= 1'b1;
        repeat (15) @(posedge clk);
        se0 <= 1'b0;
        rd_check("otg se0", 8'h18, 32'h1, 32'h1);
        host_fw_model_inst.wr(8'h18, 32'h5);
        host_fw_model_inst.wr(8'h1c, 32'h0);
        tick_gap();
        check_word("fs period", 32'd20, n, '1);
        rd_check("tick bit", 8'h18, 32'h4, 32'h4);
        @(posedge clk);
        hs <= 1'b1;
        tick_gap();
        tick_gap();
        check_word("hs period", 32'd5, n, '1);
        finish_test();
    end
endmodule
bind usb_device_status_regs usb_status_checker #(
    .FS_CYCLES(FS_CYCLES), .HS_CYCLES(HS_CYCLES), .PART_CODE(PART_CODE),
    .HW_REVISION(HW_REVISION)
) usb_status_checker_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .high_speed(high_speed), .bus_reset_event(bus_reset_event),
    .frame_tick(frame_tick), .otg_mode(otg_mode));
